// >>> rpm_defs.vh
// Register map and reset values for the receive pattern matcher.
// Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
`ifndef RPM_DEFS_VH
`define RPM_DEFS_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define RPM_IDX_PAT_FIRST  12'h4A8
`define RPM_IDX_PAT_LAST   12'h4C7
`define RPM_IDX_MASK_LO    12'h4C8
`define RPM_IDX_MASK_MID   12'h4C9
`define RPM_IDX_MASK_HI_A  12'h4CA
`define RPM_IDX_MASK_HI_B  12'h4CB
`define RPM_IDX_START      12'h4CC
`define RPM_IDX_STATUS     12'h4CD

// ************************************************************
// Field positions and widths
// ************************************************************
`define RPM_PAT_HI_MSB     15
`define RPM_PAT_HI_LSB     8
`define RPM_PAT_LO_MSB     7
`define RPM_PAT_LO_LSB     0
`define RPM_START_MSB      5
`define RPM_START_LSB      0
`define RPM_STAT_LAST_BIT  0
`define RPM_STAT_VALID_BIT 1
`define RPM_STAT_CNT_MSB   31
`define RPM_STAT_CNT_LSB   16

// ************************************************************
// Reset values and bus answers
// ************************************************************
`define RPM_RST_PAT        16'h0000
`define RPM_RST_MASK       16'h0000
`define RPM_RST_START      6'h0C
`define RPM_RESP_OKAY      2'h0
`define RPM_RESP_SLVERR    2'h2

`endif

// >>> rpm_frame_cmp.v
// Byte-by-byte comparison of one received frame against the stored pattern.
// Assumes rx inputs come from logic on mclk; the parent supplies the pattern
// byte for cmpPos in the same cycle.
`timescale 1ns/1ps
`include "rpm_defs.vh"

module rpm_frame_cmp #(
   parameter PAT_BYTES = 64
) (
   input  wire                 mclk,      // System clock
   input  wire                 rst_n,     // Synchronous reset, active low
   input  wire                 rxValid,   // Frame byte strobe
   input  wire                 rxSof,     // First byte after delimiter
   input  wire                 rxEof,     // Last byte of frame
   input  wire [7:0]           rxData,    // Frame byte
   input  wire [5:0]           startPt,   // Comparison start offset
   input  wire [PAT_BYTES-1:0] maskAll,   // One mask bit per pattern byte
   input  wire [7:0]           patByte,   // Pattern byte at cmpPos
   output wire [5:0]           cmpPos,    // Pattern position of this byte
   output reg                  doneStb_q, // Frame finished, one cycle
   output reg                  match_q    // Result of finished frame
);

   reg  [7:0]           idx_q;     // Byte index of next frame byte
   reg  [PAT_BYTES-1:0] pend_q;    // Unmasked bytes not yet matched
   reg                  mis_q;     // A compared byte differed
   reg                  inFrame_q; // Between first and last byte
   wire [7:0]           idxCur;
   wire [7:0]           relPos;
   wire                 inWin;
   wire                 live;
   wire [PAT_BYTES-1:0] pendBase;
   wire [PAT_BYTES-1:0] posBit;
   wire                 mustCmp;
   wire [PAT_BYTES-1:0] pendN;
   wire                 misN;

   // Index 0 is the first byte after the delimiter
   assign idxCur   = rxSof ? 8'h00 : idx_q;
   assign relPos   = idxCur - {2'b00, startPt};
   assign inWin    = (idxCur >= {2'b00, startPt}) && (relPos < PAT_BYTES);
   assign cmpPos   = relPos[5:0];
   assign live     = rxValid && (rxSof || inFrame_q);
   // Masks are sampled at frame start so a mid-frame write cannot split a frame
   assign pendBase = rxSof ? ~maskAll : pend_q;
   assign posBit   = {{(PAT_BYTES-1){1'b0}}, 1'b1} << cmpPos;
   assign mustCmp  = live && inWin && ((pendBase & posBit) != {PAT_BYTES{1'b0}});
   assign pendN    = (mustCmp && (patByte == rxData)) ? (pendBase & ~posBit) : pendBase;
   assign misN     = (rxSof ? 1'b0 : mis_q) | (mustCmp && (patByte != rxData));

   // ************************************************************
   // Frame tracking
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         idx_q     <= 8'h00;
         pend_q    <= {PAT_BYTES{1'b0}};
         mis_q     <= 1'b0;
         inFrame_q <= 1'b0;
         doneStb_q <= 1'b0;
         match_q   <= 1'b0;
      end else begin
         doneStb_q <= 1'b0;
         if (live) begin
            // Saturate so long frames never wrap into the window again
            idx_q     <= (idxCur == 8'hFF) ? 8'hFF : idxCur + 8'h01;
            pend_q    <= pendN;
            mis_q     <= misN;
            inFrame_q <= !rxEof;
            if (rxEof) begin
               doneStb_q <= 1'b1;
               // Unmasked bytes beyond a short frame count as not equal
               match_q   <= !misN && (pendN == {PAT_BYTES{1'b0}});
            end
         end
      end
   end

endmodule // rpm_frame_cmp

// >>> rpm_pattern_match.v
// Receive pattern matcher: pattern and mask registers over AXI4-Lite and
// a per-frame comparison of received bytes against the pattern.
// Assumes rx byte strobes come from receive logic on mclk, one byte a cycle.
//
// Functional notes
// - Mask bits for pattern bytes 16 to 31 sit in one 16-bit field, bit n for byte 16+n.
// - Mask bits for pattern bytes 32 to 47 sit in their own 16-bit register.
// - Mask bits for pattern bytes 48 to 63 sit in a third 16-bit register.
// - A mask bit of one removes its pattern byte from the comparison, zero keeps it.
// - A 6-bit start field sets how many bytes after the delimiter comparison begins.
// - Start value zero compares from the first byte after the delimiter, each step one byte later.
// - The start field resets to twelve, skipping both six-byte addresses.
// - The 64 pattern bytes sit two per 16-bit register, higher-numbered byte in the upper half.
// - Mask bits for pattern bytes 0 to 15 sit in a further 16-bit register.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "rpm_defs.vh"

module rpm_pattern_match #(
   parameter ADDR_W    = 14,
   parameter PAT_BYTES = 64
) (
   input  wire              mclk,          // System clock, 40 MHz
   input  wire              rst_n,         // Synchronous reset, active low
   input  wire [ADDR_W-1:0] s_axi_awaddr,  // Write address
   input  wire              s_axi_awvalid, // Write address valid
   output reg               s_axi_awready, // Write address ready
   input  wire [31:0]       s_axi_wdata,   // Write data
   input  wire [3:0]        s_axi_wstrb,   // Write byte lanes
   input  wire              s_axi_wvalid,  // Write data valid
   output reg               s_axi_wready,  // Write data ready
   output reg  [1:0]        s_axi_bresp,   // Write response
   output reg               s_axi_bvalid,  // Write response valid
   input  wire              s_axi_bready,  // Write response ready
   input  wire [ADDR_W-1:0] s_axi_araddr,  // Read address
   input  wire              s_axi_arvalid, // Read address valid
   output reg               s_axi_arready, // Read address ready
   output reg  [31:0]       s_axi_rdata,   // Read data
   output reg  [1:0]        s_axi_rresp,   // Read response
   output reg               s_axi_rvalid,  // Read data valid
   input  wire              s_axi_rready,  // Read data ready
   input  wire              rxValid,       // Received byte strobe
   input  wire              rxSof,         // First byte after delimiter
   input  wire              rxEof,         // Last byte of frame
   input  wire [7:0]        rxData,        // Received byte
   output wire              frameDone,     // Frame evaluated, one cycle
   output wire              patternMatch   // Result, valid with frameDone
);

   // ************************************************************
   // Register storage
   // ************************************************************
   reg  [15:0]          patWord_q [0:31]; // Two pattern bytes per word
   reg  [15:0]          maskLo_q;         // Bytes 0 to 15
   reg  [15:0]          maskMid_q;        // Bytes 16 to 31
   reg  [15:0]          maskHiA_q;        // Bytes 32 to 47
   reg  [15:0]          maskHiB_q;        // Bytes 48 to 63
   reg  [5:0]           start_q;          // Comparison start point
   reg                  lastMatch_q;      // Result of latest frame
   reg                  resValid_q;       // A frame has been evaluated
   reg  [15:0]          matchCnt_q;       // Matching frames, wraps
   reg  [ADDR_W-1:0]    awAddr_q;         // Held write address
   reg                  awHeld_q;
   reg  [31:0]          wData_q;          // Held write data
   reg  [3:0]           wStrb_q;
   reg                  wHeld_q;
   integer              i;

   wire [PAT_BYTES-1:0] maskAll;
   wire [5:0]           cmpPos;
   wire [15:0]          cmpWord;
   wire [7:0]           patByte;
   wire [11:0]          wIdx;
   wire [11:0]          rIdx;
   wire [11:0]          wPatSel;
   wire                 wIsPat;
   wire                 wMapped;
   wire                 doWrite;
   wire                 doRead;
   wire                 cmpDone;
   wire                 cmpMatch;
   wire [32:0]          rdVal;

   // Mask bit n covers pattern byte n across the four mask registers
   assign maskAll = {maskHiB_q, maskHiA_q, maskMid_q, maskLo_q};

   // Even byte in the low half, odd byte in the high half
   assign cmpWord = patWord_q[cmpPos[5:1]];
   assign patByte = cmpPos[0] ? cmpWord[`RPM_PAT_HI_MSB:`RPM_PAT_HI_LSB]
                              : cmpWord[`RPM_PAT_LO_MSB:`RPM_PAT_LO_LSB];

   // ************************************************************
   // Frame comparison
   // ************************************************************
   rpm_frame_cmp #(
      .PAT_BYTES (PAT_BYTES)
   ) uCmp (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .rxValid   (rxValid),
      .rxSof     (rxSof),
      .rxEof     (rxEof),
      .rxData    (rxData),
      .startPt   (start_q),
      .maskAll   (maskAll),
      .patByte   (patByte),
      .cmpPos    (cmpPos),
      .doneStb_q (cmpDone),
      .match_q   (cmpMatch)
   );

   // Both come straight from flip-flops inside the comparator
   assign frameDone    = cmpDone;
   assign patternMatch = cmpMatch;

   // ************************************************************
   // Address decode
   // ************************************************************
   assign wIdx    = awAddr_q[13:2];
   assign rIdx    = s_axi_araddr[13:2];
   assign wIsPat  = (wIdx >= `RPM_IDX_PAT_FIRST) && (wIdx <= `RPM_IDX_PAT_LAST);
   assign wPatSel = wIdx - `RPM_IDX_PAT_FIRST;
   assign wMapped = wIsPat || (wIdx >= `RPM_IDX_MASK_LO && wIdx <= `RPM_IDX_STATUS);
   assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign doRead  = s_axi_arvalid && s_axi_arready;
   assign rdVal   = readReg(rIdx);

   // Merge a 16-bit register with the low two write lanes
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] dat;
      input [3:0]  stb;
      begin
         merge16 = old;
         if (stb[0]) begin
            merge16[7:0] = dat[7:0];
         end
         if (stb[1]) begin
            merge16[15:8] = dat[15:8];
         end
      end
   endfunction

   // Read value of one register index; unmapped reads as zero
   function [32:0] readReg;
      input [11:0] idx;
      reg   [11:0] sub;
      begin
         sub     = idx - `RPM_IDX_PAT_FIRST;
         readReg = {1'b0, 32'h00000000};
         if (idx >= `RPM_IDX_PAT_FIRST && idx <= `RPM_IDX_PAT_LAST) begin
            readReg = {1'b1, 16'h0000, patWord_q[sub[4:0]]};
         end else begin
            case (idx)
               `RPM_IDX_MASK_LO:  readReg = {1'b1, 16'h0000, maskLo_q};
               `RPM_IDX_MASK_MID: readReg = {1'b1, 16'h0000, maskMid_q};
               `RPM_IDX_MASK_HI_A: readReg = {1'b1, 16'h0000, maskHiA_q};
               `RPM_IDX_MASK_HI_B: readReg = {1'b1, 16'h0000, maskHiB_q};
               `RPM_IDX_START:    readReg = {1'b1, 26'h0000000, start_q};
               `RPM_IDX_STATUS:   readReg = {1'b1, matchCnt_q, 14'h0000, resValid_q, lastMatch_q};
               default:           readReg = {1'b0, 32'h00000000};
            endcase
         end
      end
   endfunction

   // ************************************************************
   // Write channel: address and data taken in either order
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RPM_RESP_OKAY;
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= {ADDR_W{1'b0}};
         wData_q       <= 32'h00000000;
         wStrb_q       <= 4'h0;
      end else begin
         // Ready stays low while a beat is held, so one write at a time
         s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wMapped ? `RPM_RESP_OKAY : `RPM_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         for (i = 0; i < 32; i = i + 1) begin
            patWord_q[i] <= `RPM_RST_PAT;
         end
         maskLo_q  <= `RPM_RST_MASK;
         maskMid_q <= `RPM_RST_MASK;
         maskHiA_q <= `RPM_RST_MASK;
         maskHiB_q <= `RPM_RST_MASK;
         start_q   <= `RPM_RST_START;
      end else if (doWrite) begin
         if (wIsPat) begin
            patWord_q[wPatSel[4:0]] <= merge16(patWord_q[wPatSel[4:0]], wData_q, wStrb_q);
         end
         case (wIdx)
            `RPM_IDX_MASK_LO:   maskLo_q  <= merge16(maskLo_q, wData_q, wStrb_q);
            `RPM_IDX_MASK_MID:  maskMid_q <= merge16(maskMid_q, wData_q, wStrb_q);
            `RPM_IDX_MASK_HI_A: maskHiA_q <= merge16(maskHiA_q, wData_q, wStrb_q);
            `RPM_IDX_MASK_HI_B: maskHiB_q <= merge16(maskHiB_q, wData_q, wStrb_q);
            `RPM_IDX_START: begin
               // Upper bits are reserved and read back as zero
               if (wStrb_q[0]) begin
                  start_q <= wData_q[`RPM_START_MSB:`RPM_START_LSB];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // Match status, updated once per finished frame
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         lastMatch_q <= 1'b0;
         resValid_q  <= 1'b0;
         matchCnt_q  <= 16'h0000;
      end else if (cmpDone) begin
         lastMatch_q <= cmpMatch;
         resValid_q  <= 1'b1;
         if (cmpMatch) begin
            matchCnt_q <= matchCnt_q + 16'h0001;
         end
      end
   end

   // ************************************************************
   // Read channel: data registered one cycle after the address
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RPM_RESP_OKAY;
      end else begin
         if (doRead) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdVal[31:0];
            s_axi_rresp   <= rdVal[32] ? `RPM_RESP_OKAY : `RPM_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // rpm_pattern_match

// >>> rpm_pattern_match_props.sv
// Checker for the pattern matcher: bus answer timing and frame results.
// Assumes it is bound to rpm_pattern_match and sees only that module's ports.
`timescale 1ns/1ps
`include "rpm_defs.vh"
module rpm_pattern_match_props #(
   parameter ADDR_W = 14
) (
   input wire              mclk,          // Clock
   input wire              rst_n,         // Reset, active low
   input wire              s_axi_awvalid, // Write address valid
   input wire              s_axi_awready, // Write address ready
   input wire              s_axi_wvalid,  // Write data valid
   input wire              s_axi_wready,  // Write data ready
   input wire [1:0]        s_axi_bresp,   // Write response
   input wire              s_axi_bvalid,  // Write response valid
   input wire              s_axi_bready,  // Write response ready
   input wire [ADDR_W-1:0] s_axi_araddr,  // Read address
   input wire              s_axi_arvalid, // Read address valid
   input wire              s_axi_arready, // Read address ready
   input wire [31:0]       s_axi_rdata,   // Read data
   input wire [1:0]        s_axi_rresp,   // Read response
   input wire              s_axi_rvalid,  // Read valid
   input wire              s_axi_rready,  // Read ready
   input wire              rxValid,       // Byte strobe
   input wire              rxEof,         // Last byte
   input wire              frameDone,     // Frame evaluated
   input wire              patternMatch   // Frame result
);
   reg [ADDR_W-3:0] rdIdx_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Remember the index of the read under way, to judge its answer
   always @(posedge mclk) begin
      if (!rst_n) rdIdx_q <= 0;
      else if (s_axi_arvalid && s_axi_arready) rdIdx_q <= s_axi_araddr[ADDR_W-1:2];
   end

   // ********************************************************
   // Assertions
   // ********************************************************
   eof_done_a: assert property (rxValid && rxEof |=> frameDone)
      else $error("frame end without result pulse");
   done_cause_a: assert property (frameDone |-> $past(rxValid && rxEof))
      else $error("result pulse without frame end");
   result_hold_a: assert property (!frameDone |-> $stable(patternMatch))
      else $error("result changed outside frame end");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not freed");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
   start_width_a: assert property (s_axi_rvalid && rdIdx_q == `RPM_IDX_START |-> s_axi_rdata[31:6] == 26'h0)
      else $error("start field wider than six bits");
   mask_width_a: assert property (s_axi_rvalid && rdIdx_q >= `RPM_IDX_MASK_LO && rdIdx_q <= `RPM_IDX_MASK_HI_B
      |-> s_axi_rdata[31:16] == 16'h0)
      else $error("mask register wider than sixteen bits");
   unmapped_a: assert property (s_axi_rvalid && rdIdx_q < `RPM_IDX_PAT_FIRST |-> s_axi_rresp == `RPM_RESP_SLVERR)
      else $error("unmapped read not refused");

   // Main scenarios reached
   cover property (frameDone && patternMatch);
   cover property (frameDone && !patternMatch);
   cover property (s_axi_bvalid && s_axi_bresp == `RPM_RESP_SLVERR);
endmodule // rpm_pattern_match_props

bind rpm_pattern_match rpm_pattern_match_props #(.ADDR_W(ADDR_W)) u_props (
   .mclk(mclk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .rxValid(rxValid), .rxEof(rxEof), .frameDone(frameDone), .patternMatch(patternMatch));

// >>> rpm_frame_src.sv
// Link partner model: hands received frame bytes to the matcher, one a cycle.
// Assumes the bench loads frm and calls send, one frame at a time.
`timescale 1ns/1ps
module rpm_frame_src (
   input  wire       mclk,    // System clock
   output reg        rxValid, // Byte strobe
   output reg        rxSof,   // First byte after delimiter
   output reg        rxEof,   // Last byte
   output reg  [7:0] rxData   // Byte value
);
   reg [7:0] frm [0:127];
   integer   i;

   // Quiet lines until the first frame
   initial begin
      rxValid = 1'b0;
      rxSof = 1'b0;
      rxEof = 1'b0;
      rxData = 8'h00;
   end

   // Idle data shows the inverse of the last byte, so a stale value can never pass
   task send(input [7:0] n);
      begin
         for (i = 0; i < n; i = i + 1) begin
            @(posedge mclk);
            rxValid <= 1'b1;
            rxSof <= (i == 0);
            rxEof <= (i == n - 1);
            rxData <= frm[i];
         end
         @(posedge mclk);
         rxValid <= 1'b0;
         rxSof <= 1'b0;
         rxEof <= 1'b0;
         rxData <= ~frm[n-1];
      end
   endtask
endmodule // rpm_frame_src

// >>> tb_rx_frame_pattern_match_cfg.sv
// Testbench for the pattern matcher: registers over AXI4-Lite and frame results.
// Assumes the checker binds itself and rpm_frame_src drives the receive bytes.
`timescale 1ns/1ps
`include "rpm_defs.vh"
module tb_rx_frame_pattern_match_cfg;
   reg         mclk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [13:0] awaddr = 14'h0000, araddr = 14'h0000;
   reg  [31:0] wdata = 32'h00000000;
   reg  [3:0]  wstrb = 4'hF;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire        awready, wready, bvalid, arready, rvalid, rxValid, rxSof, rxEof, frameDone, patternMatch;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [7:0]  rxData;
   integer     error_cnt = 0;
   integer     compares = 0;
   integer     t;

   // Clock at 40 MHz
   always #12.5 mclk = ~mclk;

   rpm_pattern_match #(.ADDR_W(14), .PAT_BYTES(64)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
      .rxData(rxData), .frameDone(frameDone), .patternMatch(patternMatch));
   rpm_frame_src u_src (.mclk(mclk), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof), .rxData(rxData));

   // ********************************************************
   // Compare, bus and frame tasks
   // ********************************************************
   task chk_val(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk_flag(input got, input exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
         end
      end
   endtask
   // Address and data offered together; bready held until the answer
   task axi_write(input [11:0] idx, input [31:0] d, input [1:0] er);
      begin
         @(posedge mclk);
         awaddr <= {idx, 2'b00};
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while (bvalid !== 1'b1);
         chk_val({30'h0, bresp}, {30'h0, er});
         bready <= 1'b0;
      end
   endtask
   task axi_read(input [11:0] idx, input [31:0] exp, input [1:0] er);
      begin
         @(posedge mclk);
         araddr <= {idx, 2'b00};
         arvalid <= 1'b1;
         rready <= 1'b1;
         do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
         end while (rvalid !== 1'b1);
         chk_val(rdata, exp);
         chk_val({30'h0, rresp}, {30'h0, er});
         rready <= 1'b0;
      end
   endtask
   // Sends n bytes with v at pos; filler keeps bit 7 clear
   task run_frame(input [7:0] pos, input [7:0] v, input [7:0] n, input exp);
      integer i;
      integer k;
      begin
         for (i = 0; i < n; i = i + 1) u_src.frm[i] = i[7:0] ^ 8'h3C;
         u_src.frm[pos] = v;
         u_src.send(n);
         #1;
         k = 0;
         while (frameDone !== 1'b1 && k < 8) begin
            @(posedge mclk);
            #1;
            k = k + 1;
         end
         chk_flag(frameDone, 1'b1);
         chk_flag(patternMatch, exp);
      end
   endtask

   // ********************************************************
   // Scenarios
   // ********************************************************
   // Only byte b takes part; hit, miss, one-byte shift, then masked miss
   task check_one(input [5:0] b, input [5:0] s, input wrStart);
      reg [15:0] m;
      reg [7:0]  v;
      reg [7:0]  p;
      integer    r;
      begin
         v = {2'b10, b};
         p = {2'b00, s} + {2'b00, b};
         if (wrStart) axi_write(`RPM_IDX_START, {26'h3FFFFFF, s}, `RPM_RESP_OKAY);
         axi_read(`RPM_IDX_START, {26'h0, s}, `RPM_RESP_OKAY);
         for (r = 0; r < 4; r = r + 1) begin
            m = (r == b[5:4]) ? ~(16'h0001 << b[3:0]) : 16'hFFFF;
            axi_write(`RPM_IDX_MASK_LO + r, {16'hFFFF, m}, `RPM_RESP_OKAY);
            axi_read(`RPM_IDX_MASK_LO + r, {16'h0000, m}, `RPM_RESP_OKAY);
         end
         axi_write(`RPM_IDX_PAT_FIRST + b[5:1], {16'h0, b[0] ? {v, 8'h00} : {8'h00, v}}, `RPM_RESP_OKAY);
         axi_read(`RPM_IDX_PAT_FIRST + b[5:1], {16'h0, b[0] ? {v, 8'h00} : {8'h00, v}}, `RPM_RESP_OKAY);
         run_frame(p, v, {2'b00, s} + 8'h41, 1'b1);
         run_frame(p, ~v, {2'b00, s} + 8'h41, 1'b0);
         run_frame(p + 8'h01, v, {2'b00, s} + 8'h41, 1'b0);
         axi_write(`RPM_IDX_MASK_LO + b[5:4], 32'h0000FFFF, `RPM_RESP_OKAY);
         run_frame(p, ~v, {2'b00, s} + 8'h41, 1'b1);
      end
   endtask
   task test_reset_values;
      integer r;
      begin
         for (r = 0; r < 4; r = r + 1) axi_read(`RPM_IDX_MASK_LO + r, 32'h0, `RPM_RESP_OKAY);
         axi_read(`RPM_IDX_PAT_FIRST, 32'h0, `RPM_RESP_OKAY);
         axi_read(`RPM_IDX_PAT_LAST, 32'h0, `RPM_RESP_OKAY);
         axi_read(`RPM_IDX_START, 32'h0000000C, `RPM_RESP_OKAY);
      end
   endtask
   task test_unmapped;
      begin
         axi_write(12'h000, 32'hFFFFFFFF, `RPM_RESP_SLVERR);
         axi_read(12'h000, 32'h0, `RPM_RESP_SLVERR);
      end
   endtask
   // Edge bytes of every mask register, start swept up to 63
   task test_byte_windows;
      begin
         for (t = 0; t < 8; t = t + 1) check_one(t[0] ? t * 8 + 7 : t * 8, t * 9, 1'b1);
      end
   endtask

   task print_verdict;
      begin
         if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask

   // Main sequence: two reset cycles, then the scenarios
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      test_reset_values;
      test_unmapped;
      check_one(6'd16, 6'd12, 1'b0);
      test_byte_windows;
      axi_read(`RPM_IDX_STATUS, 32'h00120003, `RPM_RESP_OKAY);
      print_verdict;
   end

   // Watchdog: the run needs about 4000 cycles
   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      print_verdict;
   end
endmodule // tb_rx_frame_pattern_match_cfg
